// *** tsc_pkg.sv ***
// Shared constants and types of the timer status and count block
package tsc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] TSC_IDX_CTRL = 8'h00;
    localparam logic [7:0] TSC_IDX_CMD = 8'h05;
    localparam logic [7:0] TSC_IDX_INT_MASK = 8'h0d;
    localparam logic [7:0] TSC_IDX_INT_FLAG = 8'h0e;
    localparam logic [7:0] TSC_IDX_STATUS = 8'h0f;
    localparam logic [7:0] TSC_IDX_COUNT = 8'h10;

    // Control fields
    localparam int TSC_CTRL_EN_BIT = 0;
    localparam int TSC_CTRL_MODE16_BIT = 1;
    localparam int TSC_CTRL_SINGLE_BIT = 2;
    localparam int TSC_CTRL_DOWN_BIT = 3;
    localparam logic [3:0] TSC_CTRL_RST = 4'h0;

    // Command codes in bits 1:0 of the command register
    localparam logic [1:0] TSC_CMD_RETRIG = 2'h1;
    localparam logic [1:0] TSC_CMD_STOP = 2'h2;

    // Status fields
    localparam int TSC_ST_SYNC_BIT = 7;
    localparam int TSC_ST_UPPER_BIT = 4;
    localparam int TSC_ST_HALT_BIT = 3;
    localparam logic [7:0] TSC_STATUS_RST = 8'h08;

    // Interrupt flag and mask fields
    localparam int TSC_INT_OVF_BIT = 0;
    localparam int TSC_INT_SYNCRDY_BIT = 1;
    localparam logic [1:0] TSC_INT_RST = 2'h0;

    // Counter value
    localparam logic [15:0] TSC_COUNT_RST = 16'h0000;
    localparam logic [15:0] TSC_TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TSC_TOP_16BIT = 16'hffff;

    // Counter domain rate in bus clocks per tick, and crossing length in counter ticks
    localparam logic [3:0] TSC_CNT_DIV = 4'h4;
    localparam logic [2:0] TSC_SYNC_TICKS = 3'h2;

    typedef enum logic [1:0] {
        TSC_KIND_CTRL = 2'b00,
        TSC_KIND_COUNT_WR = 2'b01,
        TSC_KIND_CMD = 2'b10,
        TSC_KIND_COUNT_RD = 2'b11
    } tsc_kind_t;

    typedef enum logic [1:0] {
        TSC_SYNC_IDLE = 2'b00,
        TSC_SYNC_WAIT = 2'b01,
        TSC_SYNC_DONE = 2'b10
    } tsc_sync_state_t;

endpackage

// *** tsc_sync_engine.sv ***
// Carries one register transfer into the counter domain
`timescale 1ns/1ps
module tsc_sync_engine
    import tsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cnt_tick,
    tsc_sync_if.engine sif
);

    tsc_sync_state_t state_ff;
    logic [2:0] ticks_ff;
    tsc_kind_t kind_ff;
    logic [15:0] data_ff;

    // Transfer sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= TSC_SYNC_IDLE;
            ticks_ff <= 3'h0;
        end else begin
            unique case (state_ff)
                TSC_SYNC_IDLE: begin
                    ticks_ff <= 3'h0;
                    if (sif.start) begin
                        state_ff <= TSC_SYNC_WAIT;
                    end
                end
                TSC_SYNC_WAIT: begin
                    if (cnt_tick) begin
                        ticks_ff <= ticks_ff + 3'h1;
                        if (ticks_ff == TSC_SYNC_TICKS - 3'h1) begin
                            state_ff <= TSC_SYNC_DONE;
                        end
                    end
                end
                TSC_SYNC_DONE: begin
                    state_ff <= TSC_SYNC_IDLE;
                end
                default: begin
                    state_ff <= TSC_SYNC_IDLE;
                end
            endcase
        end
    end

    // Request payload held for the whole transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_ff <= TSC_KIND_CTRL;
            data_ff <= 16'h0000;
        end else if (state_ff == TSC_SYNC_IDLE && sif.start) begin
            kind_ff <= sif.kind;
            data_ff <= sif.wdata;
        end
    end

    assign sif.busy = (state_ff != TSC_SYNC_IDLE); // R1 R2
    assign sif.done = (state_ff == TSC_SYNC_DONE);
    assign sif.done_kind = kind_ff;
    assign sif.done_data = data_ff;

endmodule // tsc_sync_engine

// *** tsc_sync_if.sv ***
// Request and completion signals of the domain crossing engine
`timescale 1ns/1ps
interface tsc_sync_if
    import tsc_pkg::*;
();
    logic start;
    tsc_kind_t kind;
    logic [15:0] wdata;
    logic busy;
    logic done;
    tsc_kind_t done_kind;
    logic [15:0] done_data;

    modport requester (
        output start, kind, wdata,
        input busy, done, done_kind, done_data
    );

    modport engine (
        input start, kind, wdata,
        output busy, done, done_kind, done_data
    );
endinterface

// *** tsc_timer_status_count.sv ***
// APB timer unit with status flags and synchronized counter value
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// R1: Sync-in-progress bit 7 sets when transfer starts
// R2: Sync-in-progress clears when transfer finishes
// R3: Chained upper flag bit 4 tracks 32-bit pair
// R4: Halted bit 3 on disable, stop, single-pass wrap
// R5: 8-bit count in bits 7:0 at 0x10
// R6: 16-bit count uses bits 15:8 as well
// R7: Count access synchronized; guarded writes are blocked
// R8: Halted clears when counting resumes
module tsc_timer_status_count
    import tsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic peripheral_write_guard,
    input wire logic chain_upper_unit,
    input wire logic pair_lower_is_32bit,
    output logic irq
);

    // True when the bus address selects the given register index
    function automatic logic reg_hit(input logic [11:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0)
                  && (addr[9:2] == idx);
    endfunction

    // Wrap value of the counter in the selected width
    function automatic logic [15:0] count_top(input logic mode16);
        count_top = mode16 ? TSC_TOP_16BIT : TSC_TOP_8BIT;
    endfunction

    tsc_sync_if sif ();

    logic [3:0] div_ff;
    logic cnt_tick;
    logic [3:0] ctrl_shadow_ff;
    logic ctrl_en_ff;
    logic mode16_ff;
    logic single_ff;
    logic down_ff;
    logic [15:0] count_ff;
    logic halted_ff;
    logic [1:0] int_flag_ff;
    logic [1:0] int_mask_ff;
    logic irq_ff;
    logic [31:0] prdata_ff;
    logic rd_launched_ff;
    logic rd_ready_ff;

    logic setup;
    logic access;
    logic hit_ctrl;
    logic hit_cmd;
    logic hit_mask;
    logic hit_flag;
    logic hit_status;
    logic hit_count;
    logic mapped;
    logic guarded_wr;
    logic sync_wr;
    logic sync_rd;
    logic start;
    logic running;
    logic at_wrap;
    logic wrap_evt;
    logic apply_ctrl;
    logic apply_cnt;
    logic apply_cmd;
    logic [15:0] sync_data;
    logic [7:0] status_val;
    logic flag_wr;

    // Counter domain rate: one enable pulse every few bus clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= 4'h0;
        end else if (div_ff == TSC_CNT_DIV - 4'h1) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end

    assign cnt_tick = (div_ff == TSC_CNT_DIV - 4'h1);

    tsc_sync_engine u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .cnt_tick(cnt_tick),
        .sif(sif)
    );

    // Bus decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_ctrl = reg_hit(paddr, TSC_IDX_CTRL);
    assign hit_cmd = reg_hit(paddr, TSC_IDX_CMD);
    assign hit_mask = reg_hit(paddr, TSC_IDX_INT_MASK);
    assign hit_flag = reg_hit(paddr, TSC_IDX_INT_FLAG);
    assign hit_status = reg_hit(paddr, TSC_IDX_STATUS);
    assign hit_count = reg_hit(paddr, TSC_IDX_COUNT);
    assign mapped = hit_ctrl || hit_cmd || hit_mask || hit_flag
                    || hit_status || hit_count;

    // Writes to writable registers are refused under the guard
    assign guarded_wr = access && pwrite && peripheral_write_guard
                        && (hit_ctrl || hit_cmd || hit_mask || hit_flag
                            || hit_count); // R7

    // Control, command and count writes cross into the counter domain
    assign sync_wr = access && pwrite && !peripheral_write_guard
                     && (hit_ctrl || hit_cmd || hit_count); // R7
    assign sync_rd = access && !pwrite && hit_count; // R7

    // A new transfer waits until the previous one has finished
    assign start = !sif.busy && (sync_wr
                   || (sync_rd && !rd_launched_ff && !rd_ready_ff));

    assign sif.start = start; // R1
    assign sif.wdata = pwdata[15:0];

    always_comb begin
        if (!pwrite) begin
            sif.kind = TSC_KIND_COUNT_RD;
        end else if (hit_ctrl) begin
            sif.kind = TSC_KIND_CTRL;
        end else if (hit_cmd) begin
            sif.kind = TSC_KIND_CMD;
        end else begin
            sif.kind = TSC_KIND_COUNT_WR;
        end
    end

    // Bus answer
    always_comb begin
        if (!access) begin
            pready = 1'b0;
        end else if (sync_wr) begin
            pready = start;
        end else if (sync_rd) begin
            pready = rd_ready_ff;
        end else begin
            pready = 1'b1;
        end
    end

    assign pslverr = access && pready && (!mapped || guarded_wr);

    // Transfer results applied in the counter domain
    assign sync_data = sif.done_data;
    assign apply_ctrl = sif.done && (sif.done_kind == TSC_KIND_CTRL);
    assign apply_cnt = sif.done && (sif.done_kind == TSC_KIND_COUNT_WR);
    assign apply_cmd = sif.done && (sif.done_kind == TSC_KIND_CMD);

    // Control value as software wrote it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_shadow_ff <= TSC_CTRL_RST;
        end else if (sync_wr && start && hit_ctrl) begin
            ctrl_shadow_ff <= pwdata[3:0];
        end
    end

    // Control value in effect in the counter domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_ff <= TSC_CTRL_RST[TSC_CTRL_EN_BIT];
            mode16_ff <= TSC_CTRL_RST[TSC_CTRL_MODE16_BIT];
            single_ff <= TSC_CTRL_RST[TSC_CTRL_SINGLE_BIT];
            down_ff <= TSC_CTRL_RST[TSC_CTRL_DOWN_BIT];
        end else if (apply_ctrl) begin
            ctrl_en_ff <= sync_data[TSC_CTRL_EN_BIT];
            mode16_ff <= sync_data[TSC_CTRL_MODE16_BIT];
            single_ff <= sync_data[TSC_CTRL_SINGLE_BIT];
            down_ff <= sync_data[TSC_CTRL_DOWN_BIT];
        end
    end

    // Counting engine
    assign running = ctrl_en_ff && !halted_ff;
    assign at_wrap = down_ff ? (count_ff == 16'h0000)
                             : (count_ff == count_top(mode16_ff));
    assign wrap_evt = cnt_tick && running && at_wrap && !sif.done;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= TSC_COUNT_RST;
        end else if (apply_cnt) begin
            if (mode16_ff) begin
                count_ff <= sync_data; // R6
            end else begin
                count_ff <= {8'h00, sync_data[7:0]}; // R5
            end
        end else if (apply_cmd && sync_data[1:0] == TSC_CMD_RETRIG) begin
            count_ff <= down_ff ? count_top(mode16_ff) : TSC_COUNT_RST;
        end else if (apply_ctrl && !sync_data[TSC_CTRL_MODE16_BIT]) begin
            count_ff <= {8'h00, count_ff[7:0]}; // R5
        end else if (cnt_tick && running) begin
            if (at_wrap) begin
                count_ff <= down_ff ? count_top(mode16_ff) : 16'h0000;
            end else if (down_ff) begin
                count_ff <= count_ff - 16'h0001;
            end else begin
                count_ff <= count_ff + 16'h0001;
            end
        end
    end

    // Stopped state of the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted_ff <= TSC_STATUS_RST[TSC_ST_HALT_BIT];
        end else if (apply_ctrl) begin
            if (!sync_data[TSC_CTRL_EN_BIT]) begin
                halted_ff <= 1'b1; // R4
            end else if (!ctrl_en_ff) begin
                halted_ff <= 1'b0; // R8
            end
        end else if (apply_cmd) begin
            if (sync_data[1:0] == TSC_CMD_STOP) begin
                halted_ff <= 1'b1; // R4
            end else if (sync_data[1:0] == TSC_CMD_RETRIG) begin
                halted_ff <= !ctrl_en_ff; // R8
            end
        end else if (wrap_evt && single_ff) begin
            halted_ff <= 1'b1; // R4
        end
    end

    // Status register view
    always_comb begin
        status_val = 8'h00;
        status_val[TSC_ST_SYNC_BIT] = sif.busy; // R1 R2
        status_val[TSC_ST_UPPER_BIT] = chain_upper_unit
                                       && pair_lower_is_32bit; // R3
        status_val[TSC_ST_HALT_BIT] = halted_ff; // R4
    end

    // Interrupt flags: set wins over a write-one clear
    assign flag_wr = access && pwrite && hit_flag && !peripheral_write_guard;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_flag_ff <= TSC_INT_RST;
        end else begin
            if (wrap_evt) begin
                int_flag_ff[TSC_INT_OVF_BIT] <= 1'b1;
            end else if (flag_wr && pwdata[TSC_INT_OVF_BIT]) begin
                int_flag_ff[TSC_INT_OVF_BIT] <= 1'b0;
            end
            if (sif.done) begin
                int_flag_ff[TSC_INT_SYNCRDY_BIT] <= 1'b1;
            end else if (flag_wr && pwdata[TSC_INT_SYNCRDY_BIT]) begin
                int_flag_ff[TSC_INT_SYNCRDY_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_ff <= TSC_INT_RST;
        end else if (access && pwrite && hit_mask
                     && !peripheral_write_guard) begin
            int_mask_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(int_flag_ff & int_mask_ff);
        end
    end

    assign irq = irq_ff;

    // Synchronized count read bookkeeping
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_launched_ff <= 1'b0;
            rd_ready_ff <= 1'b0;
        end else if (rd_ready_ff && access) begin
            rd_launched_ff <= 1'b0;
            rd_ready_ff <= 1'b0;
        end else if (start && !pwrite) begin
            rd_launched_ff <= 1'b1;
        end else if (rd_launched_ff && sif.done
                     && sif.done_kind == TSC_KIND_COUNT_RD) begin
            rd_ready_ff <= 1'b1;
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_launched_ff && sif.done
                     && sif.done_kind == TSC_KIND_COUNT_RD) begin
            prdata_ff <= {16'h0000, count_ff}; // R5 R6 R7
        end else if (setup && !pwrite) begin
            if (hit_ctrl) begin
                prdata_ff <= {28'h0000000, ctrl_shadow_ff};
            end else if (hit_mask) begin
                prdata_ff <= {30'h0, int_mask_ff};
            end else if (hit_flag) begin
                prdata_ff <= {30'h0, int_flag_ff};
            end else if (hit_status) begin
                prdata_ff <= {24'h000000, status_val};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_ff;

endmodule // tsc_timer_status_count

// *** tsc_timer_status_count_props.sv ***
// Port checker of the timer status and count block
`timescale 1ns/1ps
module tsc_props
    import tsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic peripheral_write_guard,
    input wire logic chain_upper_unit,
    input wire logic pair_lower_is_32bit,
    input wire logic irq
);
    localparam logic [11:0] ST_A = {2'b00, TSC_IDX_STATUS, 2'b00};
    localparam logic [11:0] CN_A = {2'b00, TSC_IDX_COUNT, 2'b00};
    logic acc;
    logic m16_ff;
    assign acc = psel && penable && pready;
    // Tracks the width mode last accepted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m16_ff <= 1'b0;
        end else if (acc && pwrite && !pslverr && paddr == 12'h000) begin
            m16_ff <= pwdata[TSC_CTRL_MODE16_BIT];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_guard;
        acc && pwrite && peripheral_write_guard |-> pslverr;
    endproperty
    a_guard: assert property (p_guard) else $error("guarded write ok");
    property p_phase;
        pready |-> psel && penable;
    endproperty
    a_phase: assert property (p_phase) else $error("stray ready");
    property p_cwait;
        $rose(penable) && psel && !pwrite && paddr == CN_A |-> !pready;
    endproperty
    a_cwait: assert property (p_cwait) else $error("count read unsynced");
    property p_cbound;
        $rose(penable) && psel && !pwrite && paddr == CN_A |-> ##[1:40] pready;
    endproperty
    a_cbound: assert property (p_cbound) else $error("count read hangs");
    property p_sfast;
        $rose(penable) && psel && paddr == ST_A |-> pready && !pslverr;
    endproperty
    a_sfast: assert property (p_sfast) else $error("status read slow");
    property p_chain;
        acc && !pwrite && paddr == ST_A
            |-> prdata[4] == (chain_upper_unit && pair_lower_is_32bit);
    endproperty
    a_chain: assert property (p_chain) else $error("chained flag wrong");
    property p_szero;
        acc && !pwrite && paddr == ST_A |-> (prdata & 32'hffffff67) == 32'h0;
    endproperty
    a_szero: assert property (p_szero) else $error("status spare bits");
    property p_c8;
        acc && !pwrite && paddr == CN_A && !m16_ff |-> prdata[31:8] == 24'h0;
    endproperty
    a_c8: assert property (p_c8) else $error("8-bit count wide");
    property p_c16;
        acc && !pwrite && paddr == CN_A && m16_ff |-> prdata[31:16] == 16'h0;
    endproperty
    a_c16: assert property (p_c16) else $error("16-bit count wide");
    c_guard: cover property (acc && pwrite && peripheral_write_guard);
    c_cnt: cover property (acc && !pwrite && paddr == CN_A);
    c_busy: cover property (acc && !pwrite && paddr == ST_A && prdata[7]);
    c_irq: cover property (irq);
endmodule // tsc_props

bind tsc_timer_status_count tsc_props u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .peripheral_write_guard, .chain_upper_unit, .pair_lower_is_32bit, .irq);

// *** tsc_timer_status_count_tb.sv ***
// Self-checking bench of the timer status and count block
`timescale 1ns/1ps
module tsc_timer_status_count_tb;
    import tsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, errv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, prev;
    logic guard, chain, pair;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    tsc_timer_status_count uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .peripheral_write_guard(guard), .chain_upper_unit(chain),
        .pair_lower_is_32bit(pair), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] m,
                      input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rdv & m, exp);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic e);
        apb(1'b1, idx, d);
        chk({31'h0, errv}, {31'h0, e});
    endtask
    task automatic sync_wait();
        int n;
        n = 0;
        apb(1'b0, TSC_IDX_STATUS, 32'h0);
        while (rdv[7] !== 1'b0 && n < 60) begin
            n++;
            apb(1'b0, TSC_IDX_STATUS, 32'h0);
        end
        chk(rdv & 32'h80, 32'h0);
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, {31'h0, v});
    endtask
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, guard, chain, pair} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(TSC_IDX_STATUS, 32'hffffffff, {24'h0, TSC_STATUS_RST});
        rd(TSC_IDX_COUNT, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            chain <= i[0];
            pair <= i[1];
            rd(TSC_IDX_STATUS, 32'h10, (i == 3) ? 32'h10 : 32'h0);
        end
        wr(TSC_IDX_CTRL, 32'h2, 1'b0);
        rd(TSC_IDX_STATUS, 32'h80, 32'h80);
        sync_wait();
        wr(TSC_IDX_COUNT, 32'habcd, 1'b0);
        rd(TSC_IDX_COUNT, 32'hffffffff, 32'habcd);
        guard <= 1'b1;
        wr(TSC_IDX_COUNT, 32'h5555, 1'b1);
        wr(TSC_IDX_CTRL, 32'h1, 1'b1);
        guard <= 1'b0;
        rd(TSC_IDX_COUNT, 32'hffffffff, 32'habcd);
        rd(TSC_IDX_CTRL, 32'hf, 32'h2);
        wr(TSC_IDX_CTRL, 32'h0, 1'b0);
        sync_wait();
        rd(TSC_IDX_COUNT, 32'hffffffff, 32'hcd);
        wr(TSC_IDX_COUNT, 32'h1fe, 1'b0);
        rd(TSC_IDX_COUNT, 32'hffffffff, 32'hfe);
        wr(TSC_IDX_INT_FLAG, 32'h3, 1'b0);
        wr(TSC_IDX_INT_MASK, 32'h2, 1'b0);
        irq_is(1'b0);
        wr(TSC_IDX_CTRL, 32'h2, 1'b0);
        sync_wait();
        rd(TSC_IDX_INT_FLAG, 32'h2, 32'h2);
        irq_is(1'b1);
        wr(TSC_IDX_INT_MASK, 32'h0, 1'b0);
        irq_is(1'b0);
        wr(TSC_IDX_INT_MASK, 32'h2, 1'b0);
        irq_is(1'b1);
        wr(TSC_IDX_INT_FLAG, 32'h2, 1'b0);
        irq_is(1'b0);
        wr(TSC_IDX_CTRL, 32'h3, 1'b0);
        sync_wait();
        rd(TSC_IDX_STATUS, 32'h8, 32'h0);
        apb(1'b0, TSC_IDX_COUNT, 32'h0);
        prev = rdv;
        apb(1'b0, TSC_IDX_COUNT, 32'h0);
        chk({31'h0, rdv !== prev}, 32'h1);
        wr(TSC_IDX_CMD, {30'h0, TSC_CMD_STOP}, 1'b0);
        sync_wait();
        rd(TSC_IDX_STATUS, 32'h8, 32'h8);
        wr(TSC_IDX_CMD, {30'h0, TSC_CMD_RETRIG}, 1'b0);
        sync_wait();
        rd(TSC_IDX_STATUS, 32'h8, 32'h0);
        wr(TSC_IDX_CTRL, 32'h0, 1'b0);
        sync_wait();
        rd(TSC_IDX_STATUS, 32'h8, 32'h8);
        wr(TSC_IDX_INT_FLAG, 32'h3, 1'b0);
        wr(TSC_IDX_COUNT, 32'hfd, 1'b0);
        wr(TSC_IDX_CTRL, 32'h5, 1'b0);
        sync_wait();
        repeat (60) @(posedge pclk);
        rd(TSC_IDX_STATUS, 32'h8, 32'h8);
        rd(TSC_IDX_INT_FLAG, 32'h1, 32'h1);
        wr(TSC_IDX_STATUS, 32'h0, 1'b0);
        rd(TSC_IDX_STATUS, 32'h8, 32'h8);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        close_out();
    end
endmodule // tsc_timer_status_count_tb
